// >>> src/csp_consts.vh
`ifndef CSP_CONSTS_VH
`define CSP_CONSTS_VH
// Serial mode codes in control bits (3,2).
`define CSP_MODE_LSB      2
`define CSP_MODE_EXT      2'h2
`define CSP_MODE_INT      2'h3
// Command codes in control bits (7,6).
`define CSP_CMD_LSB       6
`define CSP_CMD_NONE      2'h0
`define CSP_CMD_SEND      2'h1
`define CSP_CMD_RECV      2'h2
`define CSP_CMD_BOTH      2'h3
// Status bit positions.
`define CSP_ST_RX_FULL    7
`define CSP_ST_TX_FULL    3
`define CSP_ST_TX_BUSY    2
// Burst length and reset value of the control register.
`define CSP_BITS          8
`define CSP_CTRL_RST      8'h00
// Internal divider default, half the serial period in clocks.
`define CSP_DIV_RST       8'h01
`endif

// >>> src/csp_port.v
`include "csp_consts.vh"
`default_nettype none
// Contract
// - Every transfer is an eight-clock burst, least significant bit first.
// - Default mode shifts transmit on falling edge, samples on rising edge.
// - Control bits 3..2 enable clocked mode with internal or external clock.
// - clk_invert clear samples on rising edge; clk_invert set samples on falling edge and shifts on rising.
// - Internal clock transfers may optionally wait for a selected timer match pulse.
// - Control bits 7..6 command send, receive, or both for one byte.
// - Reading the address register returns data and starts the next receive.
// - Writing the address register loads data and starts a transmit.
// - Internal clock: loaded byte moves to shifter when idle, eight-clock burst.
// - Send code is double buffered: one shifting, one waiting.
// - Internal clock: receive code while idle makes an eight-clock burst.
// - Internal clock receive holds one waiting code while a burst shifts; a further code is dropped.
// - Receive sets ready flag at the sampling edge of the last clock: rising, or falling with clk_invert set.
// - Internal clock: receive code by the last sampling edge continues without a pause.
// - External clock: queued byte moves to shifter as soon as the engine leaves idle, before the clock arrives.
// - Receive with silent peer captures the last bit level eight times.
// - Internal serial clock never exceeds half the core clock.
// - External clock is synchronised over two to three core clocks.
// - External mode samples the data line on a core clock rising edge.
// - Received byte sets status bit 7 and interrupt; data read clears both.
// - A write to status or data register clears the transmit interrupt; a set in the same cycle wins.
module csp_port #(
	parameter BITS = `CSP_BITS
) (
	// Clock and reset.
	input  wire        mclk,
	input  wire        rst,
	// Control register write and configuration.
	input  wire        ctrl_wr,
	input  wire [7:0]  ctrl_wdata,
	input  wire        clk_invert,
	input  wire [7:0]  half_period,
	input  wire        timer_sync_en,
	input  wire        timer_sel,
	input  wire [1:0]  timer_match,
	// Data, address and status register accesses.
	input  wire        data_wr,
	input  wire        data_rd,
	input  wire        port_address_register_wr,
	input  wire        port_address_register_rd,
	input  wire        status_wr,
	input  wire [7:0]  wdata,
	output reg  [7:0]  rx_data,
	output wire [7:0]  status,
	output reg  [7:0]  ctrl_q,
	// Interrupt requests.
	output reg         rx_irq,
	output reg         tx_irq,
	// Serial pins.
	input  wire        receive_data_line,
	output reg         tx_data_line,
	input  wire        serial_clock_line_i,
	output reg         serial_clock_line_o,
	output wire        serial_clock_line_oe
);
	// Engine states: idle, waiting for a start condition, shifting a burst.
	localparam ST_IDLE  = 2'h0;
	localparam ST_WAIT  = 2'h1;
	localparam ST_SHIFT = 2'h2;

	// Decode of a command word into send and receive requests.
	function [1:0] cmd_dec;
		input [1:0] c;
		begin
			cmd_dec = {c == `CSP_CMD_RECV || c == `CSP_CMD_BOTH, c == `CSP_CMD_SEND || c == `CSP_CMD_BOTH};
		end
	endfunction

	// Mode field and command decode.
	wire [1:0] mode     = ctrl_q[`CSP_MODE_LSB+1:`CSP_MODE_LSB];
	wire       int_mode = (mode == `CSP_MODE_INT);
	wire       ext_mode = (mode == `CSP_MODE_EXT);
	wire       clk_on   = int_mode | ext_mode;
	wire [1:0] ctrl_req = ctrl_wr ? cmd_dec(ctrl_wdata[`CSP_CMD_LSB+1:`CSP_CMD_LSB]) : 2'h0;

	// Engine registers.
	reg  [1:0] state_q;
	reg  [7:0] tx_buf_q;
	reg        tx_pend_q;
	reg        rx_pend_q;
	reg  [7:0] tx_sh_q;
	reg  [7:0] rx_sh_q;
	reg        do_tx_q;
	reg        do_rx_q;
	reg  [3:0] bit_q;

	// Divider and internal clock registers.
	reg  [7:0] div_q;
	reg        sclk_q;

	// Status and pin history registers.
	reg        rx_full_q;
	reg        ext_prev_q;
	reg        rxd_s2_q;

	// Synchronised pin levels.
	wire       ext_clk_s;
	wire       rxd_s;

	// Pin inputs from the peer pass two flip-flops first.
	csp_sync u_sync_clk (
		.mclk (mclk),
		.rst  (rst),
		.d    (serial_clock_line_i),
		.q    (ext_clk_s)
	);
	csp_sync u_sync_rxd (
		.mclk (mclk),
		.rst  (rst),
		.d    (receive_data_line),
		.q    (rxd_s)
	);

	// External clock edges, found two clocks behind the pin.
	wire ext_rise = ext_clk_s & ~ext_prev_q;
	wire ext_fall = ~ext_clk_s & ext_prev_q;

	// Divider tick and reload value; a half period of zero is held at one clock.
	wire       div_tick   = (div_q == 8'h00);
	wire [7:0] div_reload = (half_period == 8'h00) ? 8'h00 : half_period - 8'h01;
	wire       int_run    = int_mode && (state_q == ST_SHIFT);

	// Next internal clock level; the pin register loads it so pin edges and strobes share one cycle.
	wire sclk_d = int_run ? (sclk_q ^ div_tick) : 1'b0;

	// The pin rises where sclk_q falls, or the other way round when the clock is inverted.
	wire int_rise = int_run && div_tick && (clk_invert ? !sclk_q : sclk_q);
	wire int_fall = int_run && div_tick && (clk_invert ? sclk_q : !sclk_q);

	// Edge roles: clk_invert moves sampling to the falling edge.
	// The leading edge of a burst always shifts, so nothing is sampled before bit 0 is out.
	wire raw_rise   = int_mode ? int_rise : (ext_mode && ext_rise);
	wire raw_fall   = int_mode ? int_fall : (ext_mode && ext_fall);
	wire samp_edge  = clk_invert ? raw_fall : raw_rise;
	wire shift_edge = clk_invert ? raw_rise : raw_fall;

	// Received bit. External mode adds one stage to line up with the clock's edge detector.
	// With the internal clock the data line lags the pin by the synchroniser, so a half
	// period shorter than three clocks would sample a stale level.
	wire rx_bit = int_mode ? rxd_s : rxd_s2_q;

	// Requests from commands and from address register accesses.
	wire send_req = ctrl_req[0] | port_address_register_wr;
	wire recv_req = ctrl_req[1] | port_address_register_rd;
	wire rd_any   = data_rd | port_address_register_rd;
	wire wr_any   = data_wr | port_address_register_wr;

	// Timer gate and burst boundaries.
	wire timer_ok    = !timer_sync_en || timer_match[timer_sel];
	wire last_bit    = (bit_q == BITS - 1);
	wire burst_start = (state_q == ST_WAIT) && (ext_mode || (int_mode && timer_ok));
	wire burst_last  = (state_q == ST_SHIFT) && samp_edge && last_bit;

	// The internal clock runs on into the next byte when work is queued by the last sampling edge.
	wire burst_more = burst_last && int_mode && timer_ok && (rx_pend_q || recv_req || tx_pend_q);
	wire load_now   = burst_start || burst_more;

	// Flag strobes: byte received, data register emptied, transmitter gone idle.
	wire rx_done  = burst_last && do_rx_q;
	wire tx_empty = load_now && tx_pend_q;
	wire tx_idle  = burst_last && !burst_more && do_tx_q && !tx_pend_q;

	// Status register view.
	assign status = {rx_full_q, 3'h0, tx_pend_q, (state_q != ST_IDLE) & do_tx_q, 2'h0};

	// The clock pin is driven only while an internal burst runs.
	assign serial_clock_line_oe = int_run;

	// Control register holds mode bits; command field is not stored.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `CSP_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_q <= {2'h0, ctrl_wdata[5:0]};
		end
	end

	// Previous synchronised clock level for edge finding, and the matching data delay.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_prev_q <= 1'b0;
			rxd_s2_q   <= 1'b0;
		end else begin
			ext_prev_q <= ext_clk_s;
			rxd_s2_q   <= rxd_s;
		end
	end

	// Divider runs only while bursting; at least two clocks per serial period.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_q  <= `CSP_DIV_RST;
			sclk_q <= 1'b0;
		end else if (int_run) begin
			if (div_tick) begin
				div_q  <= div_reload;
				sclk_q <= ~sclk_q;
			end else begin
				div_q <= div_q - 8'h01;
			end
		end else begin
			div_q  <= div_reload;
			sclk_q <= 1'b0;
		end
	end

	// Clock pin register; it idles high, or low when the clock is inverted.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			serial_clock_line_o <= 1'b1;
		end else begin
			serial_clock_line_o <= clk_invert ? sclk_d : ~sclk_d;
		end
	end

	// Transmit buffer and the send and receive codes waiting for a burst.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_buf_q  <= 8'h00;
			tx_pend_q <= 1'b0;
			rx_pend_q <= 1'b0;
		end else begin
			// Data write loads the buffer; send code tags it.
			if (wr_any) begin
				tx_buf_q <= wdata;
			end
			if (load_now) begin
				// A send code in the same cycle tags the byte now in the buffer.
				tx_pend_q <= send_req;
				rx_pend_q <= 1'b0;
			end else begin
				if (send_req) begin
					tx_pend_q <= 1'b1;
				end
				// Internal mode holds one waiting receive code while a receive burst shifts; a further code is dropped.
				if (recv_req && (ext_mode || state_q == ST_IDLE || !do_rx_q || !rx_pend_q)) begin
					rx_pend_q <= 1'b1;
				end
			end
		end
	end

	// Direction of the burst in the shifter.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			do_tx_q <= 1'b0;
			do_rx_q <= 1'b0;
		end else if (load_now) begin
			do_tx_q <= tx_pend_q;
			do_rx_q <= rx_pend_q | recv_req;
		end else if (burst_last) begin
			do_tx_q <= 1'b0;
			do_rx_q <= 1'b0;
		end
	end

	// Burst state machine.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (clk_on && (tx_pend_q || rx_pend_q)) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// External mode starts at once and waits for the peer's edges; internal waits for a timer match only when timer_sync_en is set.
					if (!clk_on) begin
						state_q <= ST_IDLE;
					end else if (burst_start) begin
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (!clk_on) begin
						state_q <= ST_IDLE;
					end else if (burst_last && !burst_more) begin
						state_q <= (tx_pend_q || rx_pend_q) ? ST_WAIT : ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Bit counter counts sampling edges of the burst.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			bit_q <= 4'h0;
		end else if (load_now) begin
			bit_q <= 4'h0;
		end else if (state_q == ST_SHIFT && samp_edge && !last_bit) begin
			bit_q <= bit_q + 4'h1;
		end
	end

	// Transmit shifter. Each shift edge drives the next bit, bit 0 first.
	// At a byte boundary the line keeps the last bit through the final sampling edge.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_sh_q      <= 8'h00;
			tx_data_line <= 1'b1;
		end else if (burst_start) begin
			tx_sh_q      <= tx_buf_q;
			tx_data_line <= tx_pend_q ? tx_buf_q[0] : 1'b1;
		end else if (burst_more) begin
			tx_sh_q <= tx_buf_q;
		end else if (state_q == ST_SHIFT && shift_edge) begin
			tx_sh_q      <= {1'b1, tx_sh_q[7:1]};
			tx_data_line <= do_tx_q ? tx_sh_q[0] : 1'b1;
		end else if (state_q == ST_IDLE) begin
			tx_data_line <= 1'b1;
		end
	end

	// Receive shifter; a silent peer leaves its last level, which fills every bit.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_sh_q <= 8'h00;
		end else if (state_q == ST_SHIFT && samp_edge) begin
			rx_sh_q <= {rx_bit, rx_sh_q[7:1]};
		end
	end

	// Receive holding register, ready flag and request; a fresh byte wins over a read.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_data   <= 8'h00;
			rx_full_q <= 1'b0;
			rx_irq    <= 1'b0;
		end else begin
			if (rd_any) begin
				rx_full_q <= 1'b0;
				rx_irq    <= 1'b0;
			end
			if (rx_done) begin
				rx_data   <= {rx_bit, rx_sh_q[7:1]};
				rx_full_q <= 1'b1;
				rx_irq    <= 1'b1;
			end
		end
	end

	// Transmit request: set when the buffer empties or the shifter goes idle; a set wins over a clear.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_irq <= 1'b0;
		end else begin
			if (wr_any || status_wr) begin
				tx_irq <= 1'b0;
			end
			if (tx_empty || tx_idle) begin
				tx_irq <= 1'b1;
			end
		end
	end
endmodule // csp_port
`default_nettype wire

// >>> src/csp_sync.v
`default_nettype none
// Two-stage synchroniser for one level from another domain.
module csp_sync (
	// Clock and reset.
	input  wire mclk,
	input  wire rst,
	// Level in and synchronised level out.
	input  wire d,
	output reg  q
);
	reg meta_q;

	// The first stage feeds only the second stage.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // csp_sync
`default_nettype wire

// >>> tb/csp_peer.sv
`default_nettype none
module csp_peer (
	// Serial lines.
	input wire logic       sclk,
	input wire logic       sdi,
	output logic           sdo,
	output logic           eclk,
	output logic           edrv,
	// Bench side.
	input wire logic       load,
	input wire logic       burst,
	input wire logic [7:0] tx,
	output logic     [7:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	int idx = 0;
	initial {eclk, edrv, rx} = 10'h200;
	// Next bit on each falling edge; the last bit stays once the byte is out.
	assign sdo = tx[idx > 7 ? 7 : (idx < 0 ? 0 : idx)];
	always @(posedge load or negedge sclk) idx = load ? -1 : idx + 1;
	always @(posedge sclk) rx <= {sdi, rx[7:1]};
	// Eight clocks at an 80 ns period; the pull-up holds the line between bursts.
	always @(posedge burst) begin
		edrv = 1;
		repeat (8) begin
			#40 eclk = 0;
			#40 eclk = 1;
		end
		#40 edrv = 0;
	end
endmodule // csp_peer
`default_nettype wire

// >>> tb/csp_port_sva.sv
`default_nettype none
module csp_port_sva #(
	parameter int BITS = 8
) (
	// Clock and reset.
	input wire logic       mclk,
	input wire logic       rst,
	// Requests.
	input wire logic       ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic       timer_sync_en,
	input wire logic [1:0] timer_match,
	input wire logic       data_rd,
	input wire logic       port_address_register_rd,
	input wire logic       status_wr,
	// Outputs watched.
	input wire logic [7:0] status,
	input wire logic [7:0] ctrl_q,
	input wire logic       rx_irq,
	input wire logic       tx_irq,
	input wire logic       serial_clock_line_o,
	input wire logic       serial_clock_line_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic       prev_q;
	logic       oe_q;
	wire        rd_any = data_rd || port_address_register_rd;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Counts clock toggles in a burst, the edge that ends it included.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q  <= 8'h00;
			prev_q <= 1'b1;
			oe_q   <= 1'b0;
		end else begin
			cnt_q  <= (serial_clock_line_oe || oe_q) ? cnt_q + 8'(serial_clock_line_o != prev_q) : 8'h00;
			prev_q <= serial_clock_line_o;
			oe_q   <= serial_clock_line_oe;
		end
	end
	a_clk_int_only: assert property (serial_clock_line_oe |-> ctrl_q[3:2] == 2'h3)
		else $error("clock driven outside internal mode");
	a_burst_whole: assert property ($fell(serial_clock_line_oe) |=> cnt_q % (2 * BITS) == 0)
		else $error("burst not whole bytes");
	a_recv_start: assert property (ctrl_wr && ctrl_wdata[7:6] == 2'h2 && ctrl_wdata[3:2] == 2'h3
		&& ctrl_q[3:2] == 2'h3 && !serial_clock_line_oe && !timer_sync_en |-> ##[1:3] serial_clock_line_oe)
		else $error("receive burst late");
	a_timer_gate: assert property (timer_sync_en && $rose(serial_clock_line_oe) |-> ($past(timer_match, 1)
		| $past(timer_match, 2) | $past(timer_match, 3) | $past(timer_match, 4)) != 2'h0)
		else $error("burst without timer match");
	a_rd_clears: assert property (rd_any |=> !status[7] && !rx_irq)
		else $error("read left receive flag");
	a_rx_holds: assert property (status[7] && !rd_any |=> status[7])
		else $error("receive flag dropped");
	a_rx_irq_flag: assert property ($rose(status[7]) |-> ##[0:1] rx_irq)
		else $error("receive irq missing");
	a_stat_clr_tx: assert property (status_wr |=> !tx_irq)
		else $error("transmit irq not cleared");
endmodule // csp_port_sva
bind csp_port csp_port_sva #(.BITS(BITS)) u_sva (.mclk, .rst, .ctrl_wr, .ctrl_wdata, .timer_sync_en, .timer_match,
	.data_rd, .port_address_register_rd, .status_wr, .status, .ctrl_q, .rx_irq, .tx_irq, .serial_clock_line_o,
	.serial_clock_line_oe);
`default_nettype wire

// >>> tb/csp_port_test.sv
`default_nettype none
module csp_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk, rst, cw, dw, dr, aw, ar, sw, tse, ld, bu;
	logic [7:0] wd, ptx, rxd, st, prx;
	logic [1:0] tm;
	logic       txl, so, soe, rxi, txi, sdo, eclk, edrv;
	int         err_total, n_checks;
	wire        sclk = soe ? so : (edrv ? eclk : 1'b1);
	// Half period of four clocks leaves room for the synchroniser on the received data line.
	csp_port u_dut (.mclk(mclk), .rst(rst), .ctrl_wr(cw), .ctrl_wdata(wd), .clk_invert(1'b0), .half_period(8'h04),
		.timer_sync_en(tse), .timer_sel(1'b0), .timer_match(tm), .data_wr(dw), .data_rd(dr),
		.port_address_register_wr(aw), .port_address_register_rd(ar), .status_wr(sw), .wdata(wd),
		.rx_data(rxd), .status(st), .ctrl_q(), .rx_irq(rxi), .tx_irq(txi), .receive_data_line(sdo),
		.tx_data_line(txl), .serial_clock_line_i(sclk), .serial_clock_line_o(so), .serial_clock_line_oe(soe));
	csp_peer u_peer (.sclk(sclk), .sdi(txl), .sdo(sdo), .eclk(eclk), .edrv(edrv), .load(ld), .burst(bu),
		.tx(ptx), .rx(prx));
	// Compares and counts.
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One access: 0 ctrl, 1 data wr, 2 data rd, 3 addr wr, 4 addr rd, 5 status wr.
	task automatic acc(input int k, input logic [7:0] v);
		wd = v;
		{cw, dw, dr, aw, ar, sw} = 6'h20 >> k;
		@(posedge mclk);
		#1 {cw, dw, dr, aw, ar, sw} = 6'h00;
		@(posedge mclk);
		#1;
	endtask
	// Loads the peer's next byte.
	task automatic peer(input logic [7:0] v);
		ptx = v;
		ld = 1;
		#1 ld = 0;
	endtask
	// Bounded wait for idle transmitter or a received byte.
	task automatic wt(input bit idle);
		for (int i = 0; i < 400; i++) begin
			@(posedge mclk);
			#1;
			if (idle ? soe === 1'b0 && st[3:2] === 2'h0 : rxi === 1'b1) return;
		end
		err_total++;
		$display("[FAIL] wait expected 1 seen 0");
		summarize();
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		mclk = 0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		{rst, cw, dw, dr, aw, ar, sw, tse, ld, bu} = 10'h200;
		{wd, ptx, tm} = 18'h0;
		err_total = 0;
		n_checks = 0;
		repeat (20) @(posedge mclk);
		#1 rst = 0;
		chk("reset status", st, 8'h00);
		acc(0, 8'h0c);
		acc(3, 8'h3c);
		wt(1);
		chk("peer byte", prx, 8'h3c);
		acc(5, 8'h00);
		chk("tx irq", {7'h0, txi}, 8'h00);
		acc(3, 8'h11);
		acc(1, 8'h22);
		acc(0, 8'h4c);
		chk("tx queued", st & 8'h0c, 8'h0c);
		wt(1);
		chk("second byte", prx, 8'h22);
		$display("test send done");
		peer(8'h96);
		acc(0, 8'h8c);
		wt(0);
		chk("rx data", rxd, 8'h96);
		chk("rx full", st & 8'h80, 8'h80);
		acc(4, 8'h00);
		wt(0);
		chk("silent peer", rxd, 8'hff);
		acc(2, 8'h00);
		chk("rx clear", st & 8'h80, 8'h00);
		$display("test receive done");
		peer(8'h5a);
		acc(1, 8'h81);
		acc(0, 8'hcc);
		wt(0);
		chk("both rx", rxd, 8'h5a);
		chk("both tx", prx, 8'h81);
		acc(2, 8'h00);
		$display("test duplex done");
		tse = 1;
		peer(8'h3e);
		acc(0, 8'h8c);
		repeat (10) @(posedge mclk);
		#1 chk("timer hold", {7'h0, soe}, 8'h00);
		tm = 2'h3;
		@(posedge mclk);
		#1 tm = 2'h0;
		wt(0);
		chk("timed rx", rxd, 8'h3e);
		acc(2, 8'h00);
		tse = 0;
		$display("test timer done");
		acc(0, 8'h08);
		peer(8'hc3);
		acc(1, 8'h6e);
		acc(0, 8'hc8);
		bu = 1;
		#1 bu = 0;
		wt(0);
		chk("ext rx", rxd, 8'hc3);
		chk("ext tx", prx, 8'h6e);
		$display("test external done");
		summarize();
	end
endmodule // csp_port_test
`default_nettype wire
